// file: shared/prs_defs.svh
// Constants of the two-wire register-access slave
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// ----------------------------------------------------------------------
// Slave addresses chosen by the select strap
// ----------------------------------------------------------------------
`define PRS_ADDR_BATT 7'h7F
`define PRS_ADDR_FLOAT 7'h7C
`define PRS_ADDR_GND 7'h7D

// ----------------------------------------------------------------------
// Strap sense codes
// ----------------------------------------------------------------------
`define PRS_SEL_GND 2'h0
`define PRS_SEL_BATT 2'h1
`define PRS_SEL_FLOAT 2'h2

// ----------------------------------------------------------------------
// Byte framing, reset values, buffer size
// ----------------------------------------------------------------------
`define PRS_BYTE_BITS 4'h8
`define PRS_DIR_BIT 0
`define PRS_PTR_RESET 8'h00
`define PRS_IDLE_BYTE 8'hFF
`define PRS_BUF_DEPTH 2

`endif

// file: shared/prs_pkg.sv
// Types of the two-wire register-access slave
package prs_pkg;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        LS_IDLE      = 4'h0,
        LS_ADDR      = 4'h1,
        LS_ADDR_ACK  = 4'h2,
        LS_REG       = 4'h3,
        LS_REG_ACK   = 4'h4,
        LS_WDATA     = 4'h5,
        LS_WDATA_ACK = 4'h6,
        LS_RDATA     = 4'h7,
        LS_RDATA_ACK = 4'h8,
        LS_IGNORE    = 4'h9
    } prs_link_state_t;

    typedef enum logic [1:0] {
        HS_IDLE    = 2'h0,
        HS_RD_ADDR = 2'h1,
        HS_RD_DATA = 2'h2,
        HS_WR      = 2'h3
    } prs_hs_state_t;

    // ------------------------------------------------------------------
    // Words crossing between the domains and leaving the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } prs_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } prs_wr_t;

endpackage

// file: rtl/prs_buf2.sv
// Small valid/ready buffer for register write words
`timescale 1ns/10ps
module prs_buf2 #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("prs_buf2: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("prs_buf2: WIDTH must be positive");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// file: rtl/prs_i2c_slave.sv
// Two-wire slave giving a host access to 8-bit control registers
`timescale 1ns/10ps
`include "prs_defs.svh"
// How it works
// - Receiver pulls data low during ninth pulse
// - Strap picks address 7F, 7C or 7D
// - Acknowledge only when seven address bits match
// - Eighth bit chooses read (1) or write (0)
// - First written byte loads the register pointer
// - Store each data byte, acknowledge, then increment; a byte arriving while the previous word is not yet taken is refused
// - Pointer set, repeated start, then read out
// - Master acknowledge advances pointer, sends next register
// - Bytes are eight bits, most significant first
// - Start and stop are data edges, clock high
// - Sample while clock high, edges abort transfer
module prs_i2c_slave #(
    parameter int BUF_DEPTH = `PRS_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    output logic sda_val,
    output logic sda_oe,
    input wire logic [1:0] address_select_pin,
    output logic wr_valid,
    input wire logic wr_ready,
    output prs_pkg::prs_wr_t wr_word,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    if (BUF_DEPTH != 2) begin : g_bad_depth
        $error("prs_i2c_slave: the write buffer holds exactly two words");
    end

    function automatic logic [6:0] sel_to_addr(input logic [1:0] sel);
        logic [6:0] a;
        a = `PRS_ADDR_GND;
        if (sel == `PRS_SEL_BATT) begin
            a = `PRS_ADDR_BATT;
        end else if (sel == `PRS_SEL_FLOAT) begin
            a = `PRS_ADDR_FLOAT;
        end
        return a;
    endfunction

    // ------------------------------------------------------------------
    // Link domain: reset, pin synchronisers, strap
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic link_rst_n_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic [1:0] sel_s1_q, sel_s2_q;
    logic [6:0] own_addr_q;
    logic strap_done_q;

    always_ff @(posedge link_clk) begin
        rst_s1_q <= nrst;
        link_rst_n_q <= rst_s1_q;
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n_q) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // Strap is caught once after reset; later pin changes are ignored
    always_ff @(posedge link_clk) begin
        sel_s1_q <= address_select_pin;
        sel_s2_q <= sel_s1_q;
        if (!link_rst_n_q) begin
            own_addr_q <= `PRS_ADDR_GND;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            own_addr_q <= sel_to_addr(sel_s2_q);
            strap_done_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: bus events
    // ------------------------------------------------------------------
    logic scl_rise, scl_fall, start_ev, stop_ev, live;
    prs_pkg::prs_link_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q, ptr_q, fetched;
    logic dir_q, oe_q, busy;
    logic byte_done, addr_hit, wr_ev, rd_first_ev, mack_ev, rx_state;
    logic req_tgl_q, ack_s1_q, ack_s2_q, rd_ok_q;
    prs_pkg::prs_req_t req_q;
    logic [7:0] rdata_q;

    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_ev = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
    assign stop_ev = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
    assign live = !start_ev && !stop_ev && strap_done_q;
    assign byte_done = (cnt_q == `PRS_BYTE_BITS);
    assign rx_state = (st_q == prs_pkg::LS_ADDR) || (st_q == prs_pkg::LS_REG)
        || (st_q == prs_pkg::LS_WDATA);
    assign addr_hit = (sh_q[7:1] == own_addr_q);
    assign busy = (req_tgl_q != ack_s2_q);
    assign wr_ev = live && scl_fall && (st_q == prs_pkg::LS_WDATA) && byte_done && !busy;
    assign rd_first_ev = live && scl_fall && (st_q == prs_pkg::LS_ADDR) && byte_done
        && addr_hit && sh_q[`PRS_DIR_BIT];
    assign mack_ev = live && scl_rise && (st_q == prs_pkg::LS_RDATA_ACK) && !sda_s2_q;
    // A fetch still in flight sends idle ones rather than stale data
    assign fetched = (busy || !rd_ok_q) ? `PRS_IDLE_BYTE : rdata_q;

    // ------------------------------------------------------------------
    // Link domain: protocol state machine
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!link_rst_n_q || !strap_done_q) begin
            st_q <= prs_pkg::LS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= prs_pkg::LS_ADDR;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= prs_pkg::LS_IDLE;
            oe_q <= 1'b0;
        end else begin
            if (scl_rise && rx_state && !byte_done) begin
                sh_q <= {sh_q[6:0], sda_s2_q};
                cnt_q <= cnt_q + 4'h1;
            end
            if (scl_rise && (st_q == prs_pkg::LS_RDATA_ACK) && sda_s2_q) begin
                st_q <= prs_pkg::LS_IGNORE;
            end
            if (scl_fall) begin
                unique case (st_q)
                    prs_pkg::LS_ADDR: begin
                        if (byte_done) begin
                            cnt_q <= 4'h0;
                            if (addr_hit) begin
                                oe_q <= 1'b1;
                                dir_q <= sh_q[`PRS_DIR_BIT];
                                st_q <= prs_pkg::LS_ADDR_ACK;
                            end else begin
                                st_q <= prs_pkg::LS_IGNORE;
                            end
                        end
                    end
                    prs_pkg::LS_ADDR_ACK, prs_pkg::LS_RDATA_ACK: begin
                        if (dir_q) begin
                            tx_q <= {fetched[6:0], 1'b0};
                            oe_q <= !fetched[7];
                            cnt_q <= 4'h1;
                            st_q <= prs_pkg::LS_RDATA;
                        end else begin
                            oe_q <= 1'b0;
                            st_q <= prs_pkg::LS_REG;
                        end
                    end
                    prs_pkg::LS_REG: begin
                        if (byte_done) begin
                            cnt_q <= 4'h0;
                            oe_q <= 1'b1;
                            st_q <= prs_pkg::LS_REG_ACK;
                        end
                    end
                    prs_pkg::LS_REG_ACK, prs_pkg::LS_WDATA_ACK: begin
                        oe_q <= 1'b0;
                        st_q <= prs_pkg::LS_WDATA;
                    end
                    prs_pkg::LS_WDATA: begin
                        if (byte_done) begin
                            cnt_q <= 4'h0;
                            // Previous word not yet taken: refuse this one
                            if (!busy) begin
                                oe_q <= 1'b1;
                                st_q <= prs_pkg::LS_WDATA_ACK;
                            end else begin
                                st_q <= prs_pkg::LS_IGNORE;
                            end
                        end
                    end
                    prs_pkg::LS_RDATA: begin
                        if (byte_done) begin
                            oe_q <= 1'b0;
                            st_q <= prs_pkg::LS_RDATA_ACK;
                        end else begin
                            oe_q <= !tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    prs_pkg::LS_IDLE, prs_pkg::LS_IGNORE: begin
                        oe_q <= 1'b0;
                    end
                    default: begin
                        oe_q <= 1'b0;
                        st_q <= prs_pkg::LS_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Link domain: register pointer
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!link_rst_n_q) begin
            ptr_q <= `PRS_PTR_RESET;
        end else if (live && scl_fall && (st_q == prs_pkg::LS_REG) && byte_done) begin
            ptr_q <= sh_q;
        end else if (live && scl_fall && (st_q == prs_pkg::LS_WDATA_ACK)) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (mack_ev) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Crossing: toggle request with held word, toggle answer
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!link_rst_n_q) begin
            req_tgl_q <= 1'b0;
            req_q <= '0;
            rd_ok_q <= 1'b0;
        end else if (wr_ev) begin
            req_q <= '{we: 1'b1, addr: ptr_q, data: sh_q};
            req_tgl_q <= !req_tgl_q;
        end else if (rd_first_ev && !busy) begin
            req_q <= '{we: 1'b0, addr: ptr_q, data: 8'h00};
            req_tgl_q <= !req_tgl_q;
            rd_ok_q <= 1'b1;
        end else if (mack_ev && !busy) begin
            req_q <= '{we: 1'b0, addr: ptr_q + 8'h01, data: 8'h00};
            req_tgl_q <= !req_tgl_q;
            rd_ok_q <= 1'b1;
        end else if (rd_first_ev || mack_ev) begin
            // Skipped fetch: never resend an older register's byte
            rd_ok_q <= 1'b0;
        end
    end

    logic ack_tgl_q;

    always_ff @(posedge link_clk) begin
        if (!link_rst_n_q) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // System domain: request service
    // ------------------------------------------------------------------
    logic req_s1_q, req_s2_q, seen_q;
    prs_pkg::prs_hs_state_t hs_q;
    logic [7:0] rd_addr_q;
    logic buf_in_ready;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Holding the answer while the buffer is full stalls the link side
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hs_q <= prs_pkg::HS_IDLE;
            seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            rd_addr_q <= 8'h00;
            rdata_q <= `PRS_IDLE_BYTE;
        end else begin
            unique case (hs_q)
                prs_pkg::HS_IDLE: begin
                    if (req_s2_q != seen_q) begin
                        seen_q <= req_s2_q;
                        rd_addr_q <= req_q.addr;
                        hs_q <= req_q.we ? prs_pkg::HS_WR : prs_pkg::HS_RD_ADDR;
                    end
                end
                prs_pkg::HS_RD_ADDR: hs_q <= prs_pkg::HS_RD_DATA;
                prs_pkg::HS_RD_DATA: begin
                    rdata_q <= rd_data;
                    ack_tgl_q <= !ack_tgl_q;
                    hs_q <= prs_pkg::HS_IDLE;
                end
                prs_pkg::HS_WR: begin
                    if (buf_in_ready) begin
                        ack_tgl_q <= !ack_tgl_q;
                        hs_q <= prs_pkg::HS_IDLE;
                    end
                end
            endcase
        end
    end

    prs_buf2 #(
        .WIDTH($bits(prs_pkg::prs_wr_t)),
        .DEPTH(BUF_DEPTH)
    ) u_wbuf (
        .clk(clk),
        .nrst(nrst),
        .in_valid(hs_q == prs_pkg::HS_WR),
        .in_ready(buf_in_ready),
        .in_data({req_q.addr, req_q.data}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    // Open drain: the line is only ever pulled low
    assign sda_val = 1'b0;
    assign sda_oe = oe_q;
    assign rd_addr = rd_addr_q;
endmodule

// file: test/prs_i2c_monitor.sv
// Checker of the two-wire slave ports, bound to the top module
`timescale 1ns/10ps
module prs_i2c_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_val,
    input wire logic sda_oe,
    input wire logic [1:0] address_select_pin,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire prs_pkg::prs_wr_t wr_word,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    a_sda_only_low: assert property (@(posedge link_clk) sda_val == 1'b0)
        else $error("sda output not tied low");
    // Raw clock high for six samples: the synchroniser delay has passed
    a_oe_stable_high: assert property (@(posedge link_clk) disable iff (!nrst)
        scl [*6] |-> $stable(sda_oe)) else $error("sda enable moved while clock high");
    a_oe_after_fall: assert property (@(posedge link_clk) disable iff (!nrst)
        $changed(sda_oe) |-> !scl && $past(scl, 7)) else $error("sda enable moved late");
    a_oe_hold_set: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(sda_oe) |=> sda_oe [*8]) else $error("low level dropped too soon");
    a_oe_hold_clr: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(sda_oe) |=> !sda_oe [*8]) else $error("release too short");
    // ------------------------------------------------------------
    // System side
    // ------------------------------------------------------------
    a_wr_word_hold: assert property (@(posedge clk) disable iff (!nrst)
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word)) else $error("write word lost");
    a_wr_drop_taken: assert property (@(posedge clk) disable iff (!nrst)
        $fell(wr_valid) |-> $past(wr_ready)) else $error("write word withdrawn");
    a_rd_addr_hold: assert property (@(posedge clk) disable iff (!nrst)
        $changed(rd_addr) |=> $stable(rd_addr)) else $error("read address not held");
    a_reset_clears: assert property (@(posedge clk)
        !nrst |=> !wr_valid && rd_addr == 8'h00) else $error("reset values wrong");
    c_word_taken: cover property (@(posedge clk) wr_valid && wr_ready);
    c_stall: cover property (@(posedge clk) wr_valid && !wr_ready);
    c_sda_pulled: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule

bind prs_i2c_slave prs_i2c_monitor u_mon (.clk(clk), .nrst(nrst), .link_clk(link_clk),
    .scl(scl), .sda(sda), .sda_val(sda_val), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .rd_addr(rd_addr), .rd_data(rd_data));

// file: test/prs_host_model.sv
// Bus master model for the two-wire link
`timescale 1ns/10ps
module prs_host_model #(
    parameter int QTR = 300
) (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Start and repeated start alike: both lines high first
    task automatic start_bus();
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic stop_bus();
        sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #QTR;
    endtask
    // Data held a quarter past the falling clock
    task automatic clock_bit(input logic b, output logic seen);
        sda_drv = b;
        #QTR scl = 1'b1;
        #QTR seen = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask
    task automatic send_byte(input logic [7:0] v, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(v[i], s);
        clock_bit(1'b1, ack_n);
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            v[i] = s;
        end
        clock_bit(last, s);
    endtask
endmodule

// file: test/tb_i2c_register_access_slave.sv
// Self-checking bench of the two-wire register-access slave
`timescale 1ns/10ps
`include "prs_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb_i2c_register_access_slave;
    logic clk, nrst, link_clk, scl, sda_drv, sda, sda_o, sda_oe, wr_valid, wr_ready, ak;
    logic [1:0] strap;
    logic [7:0] rd_addr, rd_data, v;
    prs_pkg::prs_wr_t wr_word;
    prs_pkg::prs_wr_t got[$];
    prs_pkg::prs_wr_t exp_q[$];
    int failures, compares, seed;
    logic [6:0] me;
    // Open-drain wire, pull-up when nobody pulls
    assign sda = sda_drv & !sda_oe;
    prs_i2c_slave #(.BUF_DEPTH(2)) dut (.clk(clk), .nrst(nrst), .link_clk(link_clk),
        .scl(scl), .sda(sda), .sda_val(sda_o), .sda_oe(sda_oe), .address_select_pin(strap),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_addr(rd_addr),
        .rd_data(rd_data));
    prs_host_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction
    function automatic logic [6:0] addr_of(input logic [1:0] c);
        return c == 2'h1 ? `PRS_ADDR_BATT : (c == 2'h2 ? `PRS_ADDR_FLOAT : `PRS_ADDR_GND);
    endfunction
    // Random stalls on the write port, register file answers reads
    always @(negedge clk) begin
        wr_ready <= ($random(seed) & 3) != 0;
        rd_data <= exp_reg(rd_addr);
    end
    always @(posedge clk) if (nrst && wr_valid && wr_ready) got.push_back(wr_word);
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] c);
        @(negedge clk);
        strap = c;
        nrst = 1'b0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
    endtask
    // Second byte after a mismatch must be ignored too
    task automatic check_addr(input logic [6:0] a, input logic hit);
        host.start_bus();
        host.send_byte({a, 1'b0}, ak);
        `CHK("address ack", !hit, ak)
        host.send_byte(8'h00, ak);
        `CHK("second byte ack", !hit, ak)
        host.stop_bus();
    endtask
    task automatic write_regs(input logic [7:0] r, input int n);
        logic [7:0] d;
        prs_pkg::prs_wr_t ew, gw;
        host.start_bus();
        host.send_byte({me, 1'b0}, ak);
        host.send_byte(r, ak);
        `CHK("pointer ack", 1'b0, ak)
        for (int i = 0; i < n; i++) begin
            d = $random(seed);
            host.send_byte(d, ak);
            `CHK("data ack", 1'b0, ak)
            exp_q.push_back('{addr: r + 8'(i), data: d});
        end
        host.stop_bus();
        for (int t = 0; t < 300 && got.size() < exp_q.size(); t++) @(negedge clk);
        `CHK("word count", exp_q.size(), got.size())
        // Pop once: the compare macro evaluates its arguments twice
        while (exp_q.size() > 0 && got.size() > 0) begin
            ew = exp_q.pop_front();
            gw = got.pop_front();
            `CHK("write word", ew, gw)
        end
        // Leftovers are already counted; drop them to keep later words aligned
        exp_q.delete();
        got.delete();
        repeat (25) @(negedge clk);
    endtask
    task automatic read_regs(input logic [7:0] r, input int n, input logic set_ptr);
        if (set_ptr) begin
            host.start_bus();
            host.send_byte({me, 1'b0}, ak);
            host.send_byte(r, ak);
        end
        host.start_bus();
        host.send_byte({me, 1'b1}, ak);
        `CHK("read address ack", 1'b0, ak)
        for (int i = 0; i < n; i++) begin
            host.recv_byte(i == n - 1, v);
            `CHK("read data", exp_reg(r + 8'(i)), v)
        end
        host.stop_bus();
        `CHK("sda released", 1'b0, sda_oe)
        repeat (25) @(negedge clk);
    endtask
    initial begin
        seed = 85;
        nrst = 1'b0;
        strap = 2'h0;
        wr_ready = 1'b0;
        rd_data = 8'h00;
        failures = 0;
        compares = 0;
        for (int c = 0; c < 4; c++) begin
            do_reset(2'(c));
            for (int k = 1; k < 4; k++) check_addr(addr_of(2'(k)), addr_of(2'(k)) == addr_of(2'(c)));
        end
        me = addr_of(2'h3);
        write_regs(8'hFE, 3);
        // Pointer survives the stop between the two transfers
        write_regs(8'h40, 0);
        read_regs(8'h40, 1, 1'b0);
        read_regs(8'hFE, 3, 1'b1);
        repeat (4) begin
            v = $random(seed);
            write_regs(v, 1 + ($random(seed) & 1));
            read_regs(v, 1 + ($random(seed) & 1), 1'b1);
        end
        give_verdict();
    end
endmodule
